// ### sfs_cfg.svh
// Constants for the frame status FIFO and enhancement logic
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH
// Register pointer values (point-high pointers carry bit 3)
`define SFS_IX_TX_RX_STATUS 4'h0
`define SFS_IX_RX_COND      4'h1
`define SFS_IX_IRQ_VECTOR   4'h2
`define SFS_IX_IRQ_PENDING  4'h3
`define SFS_IX_RX_CONFIG    4'h3
`define SFS_IX_MODE_CONFIG  4'h4
`define SFS_IX_TX_CONFIG    4'h5
`define SFS_IX_CNT_LOW      4'h6
`define SFS_IX_CNT_HIGH     4'h7
`define SFS_IX_SYNC_FLAG    4'h7
`define SFS_IX_DATA         4'h8
`define SFS_IX_RX_CFG_RB    4'h9
`define SFS_IX_LINE_CTRL    4'ha
`define SFS_IX_MISC         4'ha
`define SFS_IX_LINE_RB      4'hb
`define SFS_IX_BAUD_LOW     4'hc
`define SFS_IX_BAUD_HIGH    4'hd
`define SFS_IX_OPT_RB       4'he
`define SFS_IX_ENH_EN       4'hf
// enhancement_enable_reg bits
`define SFS_ENH_OPT_BIT     0
`define SFS_ENH_FIFO_BIT    2
// sdlc_option_reg bits
`define SFS_OPT_AUTO_FLAG   0
`define SFS_OPT_AUTO_EOM    1
`define SFS_OPT_AUTO_RTS    2
`define SFS_OPT_FORCE_TXD   3
`define SFS_OPT_FAST_REQ    4
`define SFS_OPT_CRC_CAPT    5
`define SFS_OPT_EXT_READ    6
// fifo_count_high bits
`define SFS_CNTH_AVAIL_BIT  6
`define SFS_CNTH_OVF_BIT    7
// tx_config request-to-send bit
`define SFS_TXC_RTS_BIT     1
// Reset values
`define SFS_REG_RESET       8'h00
// Sizes
`define SFS_CNT_W           14
`define SFS_STAT_W          5
`define SFS_FIFO_DEPTH      10
`endif

// ### sfs_pkg.sv
// Types shared by the frame status FIFO block
package sfs_pkg;
  `include "sfs_cfg.svh"

  // One stored frame: byte count and the five kept status bits
  typedef struct packed {
    logic [`SFS_CNT_W-1:0] count;
    logic [2:0]            residue;
    logic                  overrun;
    logic                  crc_err;
  } sfs_entry_t;

  // Live status and read-only images supplied by the channel core
  typedef struct packed {
    logic [7:0] tx_rx_status;
    logic [7:0] rx_cond;
    logic [7:0] irq_vector;
    logic [7:0] irq_pending;
    logic [7:0] rx_data;
    logic [7:0] misc_status;
    logic [7:0] baud_low;
    logic [7:0] baud_high;
    logic [7:0] ext_status;
  } sfs_core_stat_t;

  // Written configuration handed back to the core
  typedef struct packed {
    logic [7:0] rx_config;
    logic [7:0] mode_config;
    logic [7:0] tx_config;
    logic [7:0] sync_flag;
    logic [7:0] line_control;
    logic [7:0] enh_enable;
    logic [7:0] option;
  } sfs_cfg_regs_t;

  // Enhancement controls for the core
  typedef struct packed {
    logic auto_flag;
    logic auto_eom;
    logic force_txd_high;
    logic fast_req;
    logic crc_full;
  } sfs_ctrl_t;
endpackage : sfs_pkg

// ### sfs_frame_status.sv
// Frame status FIFO, byte counter and enhancement register logic
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Generic FIFO with valid/ready on both sides
// ---------------------------------------------------------------------
module sfs_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               used;
  } sfs_fifo_state_t;

  sfs_fifo_state_t st;
  sfs_fifo_state_t next_st;
  logic            push;
  logic            pop;

  // Pointer step that wraps at the depth, not at a power of two
  function automatic logic [AW-1:0] sfs_step(input logic [AW-1:0] p);
    sfs_step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : sfs_step

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (st.used != CW'(DEPTH));
  assign out_valid_o = (st.used != '0);
  assign out_data_o  = st.mem[st.rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Next state
  always_comb begin
    next_st = st;
    if (flush_i) begin
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
      next_st.used   = '0;
    end else begin
      if (push) begin
        next_st.mem[st.wr_ptr] = in_data_i;
        next_st.wr_ptr         = sfs_step(st.wr_ptr);
      end
      if (pop) begin
        next_st.rd_ptr = sfs_step(st.rd_ptr);
      end
      if (push && !pop) begin
        next_st.used = CW'(st.used + 1'b1);
      end else if (pop && !push) begin
        next_st.used = CW'(st.used - 1'b1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end
endmodule : sfs_fifo

// ---------------------------------------------------------------------
// Channel frame status and enhancement block
// ---------------------------------------------------------------------
module sfs_frame_status
  import sfs_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  // Register port
  input  wire logic [3:0]      reg_idx_i,
  input  wire logic            reg_rd_i,
  input  wire logic            reg_wr_i,
  input  wire logic [7:0]      reg_wdata_i,
  output logic [7:0]           reg_rdata_o,
  output logic                 reg_rvalid_o,
  // Receive events from the channel core
  input  wire logic            sdlc_mode_i,
  input  wire logic            rx_data_wr_i,
  input  wire logic            rx_flag_i,
  input  wire logic            rx_eof_i,
  input  wire logic            closing_flag_done_i,
  input  wire sfs_core_stat_t  core_stat_i,
  // Configuration and controls to the channel core
  output sfs_cfg_regs_t        cfg_o,
  output sfs_ctrl_t            ctrl_o,
  output logic                 rts_o,
  output logic                 fifo_active_o,
  output logic                 status_lost_o
);
  // -------------------------------------------------------------------
  // State and decode
  // -------------------------------------------------------------------
  typedef struct packed {
    sfs_cfg_regs_t         cfg;
    sfs_ctrl_t             ctrl;
    logic [`SFS_CNT_W-1:0] byte_cnt;
    logic                  overflow;
    logic                  avail_lat;
    logic                  armed;
    logic                  rts_hold;
    logic                  rts;
    logic [7:0]            rdata;
    logic                  rvalid;
  } sfs_state_t;

  sfs_state_t  st;
  sfs_state_t  next_st;
  sfs_entry_t  head;
  sfs_entry_t  new_entry;
  logic        fifo_en;
  logic        opt_en;
  logic        ext_rd;
  logic        active;
  logic        not_empty;
  logic        in_ready;
  logic        push_req;
  logic        pop;
  logic        use_fifo;
  logic        rd_cnt_high;
  logic        rd_status;
  logic [7:0]  status_mux;
  logic [7:0]  cnt_high;
  logic [7:0]  cnt_low;
  logic [7:0]  rd_mux;

  // Register access strobes, true only on an enabled cycle
  function automatic logic sfs_hit(input logic stb, input logic [3:0] ix,
                                   input logic [3:0] want);
    sfs_hit = stb & (ix == want);
  endfunction : sfs_hit

  // Enable bits decode independently of each other
  assign fifo_en     = st.cfg.enh_enable[`SFS_ENH_FIFO_BIT];
  assign opt_en      = st.cfg.enh_enable[`SFS_ENH_OPT_BIT];
  assign ext_rd      = opt_en & st.cfg.option[`SFS_OPT_EXT_READ];
  assign active      = fifo_en & sdlc_mode_i;
  assign rd_cnt_high = sfs_hit(reg_rd_i & ce_i, reg_idx_i, `SFS_IX_CNT_HIGH);
  assign rd_status   = sfs_hit(reg_rd_i & ce_i, reg_idx_i, `SFS_IX_RX_COND);

  // -------------------------------------------------------------------
  // Status FIFO
  // -------------------------------------------------------------------
  // Entry packs the running count and the five stored status bits
  assign new_entry.count   = st.byte_cnt;
  assign new_entry.residue = core_stat_i.rx_cond[3:1];
  assign new_entry.overrun = core_stat_i.rx_cond[5];
  assign new_entry.crc_err = core_stat_i.rx_cond[6];
  assign push_req          = active & rx_eof_i;

  // Pop only when a count-high read armed it and found data
  assign use_fifo = active & not_empty & st.armed & st.avail_lat;
  assign pop      = rd_status & use_fifo;

  sfs_fifo #(
    .WIDTH ($bits(sfs_entry_t)),
    .DEPTH (`SFS_FIFO_DEPTH)
  ) u_status_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .flush_i     (~active),
    .in_valid_i  (push_req),
    .in_ready_o  (in_ready),
    .in_data_i   (new_entry),
    .out_valid_o (not_empty),
    .out_ready_i (pop),
    .out_data_o  (head)
  );

  // -------------------------------------------------------------------
  // Read multiplexer
  // -------------------------------------------------------------------
  // Stored bits replace live ones; all-sent, parity and EOF stay live
  always_comb begin
    status_mux = core_stat_i.rx_cond;
    if (use_fifo) begin
      status_mux[3:1] = head.residue;
      status_mux[5]   = head.overrun;
      status_mux[6]   = head.crc_err;
    end
  end

  // Count bytes carry the head even when empty; software must check bit 6
  always_comb begin
    cnt_high                      = {2'b00, head.count[13:8]};
    cnt_high[`SFS_CNTH_AVAIL_BIT] = active & not_empty;
    cnt_high[`SFS_CNTH_OVF_BIT]   = st.overflow;
    cnt_low                       = head.count[7:0];
  end

  // Pointer map; images follow the enable and extended-read bits
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_idx_i)
      `SFS_IX_TX_RX_STATUS: rd_mux = core_stat_i.tx_rx_status;
      `SFS_IX_RX_COND:      rd_mux = status_mux;
      `SFS_IX_IRQ_VECTOR:   rd_mux = core_stat_i.irq_vector;
      `SFS_IX_IRQ_PENDING:  rd_mux = core_stat_i.irq_pending;
      `SFS_IX_MODE_CONFIG:  rd_mux = ext_rd ? st.cfg.mode_config
                                            : core_stat_i.tx_rx_status;
      `SFS_IX_TX_CONFIG:    rd_mux = ext_rd ? st.cfg.tx_config
                                            : status_mux;
      `SFS_IX_CNT_LOW:      rd_mux = fifo_en ? cnt_low
                                             : core_stat_i.irq_vector;
      `SFS_IX_CNT_HIGH:     rd_mux = fifo_en ? cnt_high
                                             : core_stat_i.irq_pending;
      `SFS_IX_DATA:         rd_mux = core_stat_i.rx_data;
      `SFS_IX_RX_CFG_RB:    rd_mux = ext_rd ? st.cfg.rx_config
                                            : core_stat_i.baud_high;
      `SFS_IX_MISC:         rd_mux = core_stat_i.misc_status;
      `SFS_IX_LINE_RB:      rd_mux = ext_rd ? st.cfg.line_control
                                            : core_stat_i.ext_status;
      `SFS_IX_BAUD_LOW:     rd_mux = core_stat_i.baud_low;
      `SFS_IX_BAUD_HIGH:    rd_mux = core_stat_i.baud_high;
      `SFS_IX_OPT_RB:       rd_mux = ext_rd ? st.cfg.option
                                            : core_stat_i.misc_status;
      `SFS_IX_ENH_EN:       rd_mux = core_stat_i.ext_status;
    endcase
  end

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    // Read data is captured so the bus sees a flop, one cycle later
    if (reg_rd_i) begin
      next_st.rdata  = rd_mux;
      next_st.rvalid = 1'b1;
    end
    // Configuration writes; sync flag pointer redirects when options on
    if (reg_wr_i) begin
      unique case (reg_idx_i)
        `SFS_IX_RX_CONFIG:   next_st.cfg.rx_config    = reg_wdata_i;
        `SFS_IX_MODE_CONFIG: next_st.cfg.mode_config  = reg_wdata_i;
        `SFS_IX_TX_CONFIG:   next_st.cfg.tx_config    = reg_wdata_i;
        `SFS_IX_LINE_CTRL:   next_st.cfg.line_control = reg_wdata_i;
        `SFS_IX_ENH_EN:      next_st.cfg.enh_enable   = reg_wdata_i;
        `SFS_IX_SYNC_FLAG: begin
          if (opt_en) begin
            next_st.cfg.option = reg_wdata_i;
          end else begin
            next_st.cfg.sync_flag = reg_wdata_i;
          end
        end
        default: ;
      endcase
    end
    // Count-high read latches availability and arms one pop
    if (reg_rd_i && reg_idx_i == `SFS_IX_CNT_HIGH) begin
      next_st.avail_lat = active & not_empty;
      next_st.armed     = 1'b1;
    end else if (reg_rd_i && reg_idx_i == `SFS_IX_RX_COND) begin
      next_st.armed = 1'b0;
    end
    // Overflow is sticky while enabled; clearing the enable clears it
    if (!fifo_en) begin
      next_st.overflow = 1'b0;
    end else if (push_req && !in_ready) begin
      next_st.overflow = 1'b1;
    end
    // Byte counter: flag restarts it, at one if a data write comes in the same cycle
    if (!active) begin
      next_st.byte_cnt = '0;
    end else if (rx_flag_i) begin
      next_st.byte_cnt = {{(`SFS_CNT_W-1){1'b0}}, rx_data_wr_i};
    end else if (rx_data_wr_i) begin
      next_st.byte_cnt = `SFS_CNT_W'(st.byte_cnt + 1'b1);
    end
    // Auto turnoff keeps request-to-send until the closing flag is out
    if (!(opt_en && sdlc_mode_i && st.cfg.option[`SFS_OPT_AUTO_RTS])) begin
      next_st.rts_hold = 1'b0;
    end else if (reg_wr_i && reg_idx_i == `SFS_IX_TX_CONFIG &&
                 st.cfg.tx_config[`SFS_TXC_RTS_BIT] &&
                 !reg_wdata_i[`SFS_TXC_RTS_BIT]) begin
      next_st.rts_hold = 1'b1;
    end else if (closing_flag_done_i) begin
      next_st.rts_hold = 1'b0;
    end
    next_st.rts = next_st.cfg.tx_config[`SFS_TXC_RTS_BIT] | next_st.rts_hold;
    // Options 0 to 2 need SDLC mode; 3 to 6 do not
    next_st.ctrl.auto_flag      = next_st.cfg.enh_enable[`SFS_ENH_OPT_BIT]
                                  & sdlc_mode_i
                                  & next_st.cfg.option[`SFS_OPT_AUTO_FLAG];
    next_st.ctrl.auto_eom       = next_st.cfg.enh_enable[`SFS_ENH_OPT_BIT]
                                  & sdlc_mode_i
                                  & next_st.cfg.option[`SFS_OPT_AUTO_EOM];
    next_st.ctrl.force_txd_high = next_st.cfg.enh_enable[`SFS_ENH_OPT_BIT]
                                  & next_st.cfg.option[`SFS_OPT_FORCE_TXD];
    next_st.ctrl.fast_req       = next_st.cfg.enh_enable[`SFS_ENH_OPT_BIT]
                                  & next_st.cfg.option[`SFS_OPT_FAST_REQ];
    next_st.ctrl.crc_full       = next_st.cfg.enh_enable[`SFS_ENH_OPT_BIT]
                                  & next_st.cfg.option[`SFS_OPT_CRC_CAPT];
  end

  // State register; every configuration register clears on reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs
  assign reg_rdata_o   = st.rdata;
  assign reg_rvalid_o  = st.rvalid;
  assign cfg_o         = st.cfg;
  assign ctrl_o        = st.ctrl;
  assign rts_o         = st.rts;
  assign fifo_active_o = active;
  assign status_lost_o = st.overflow;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking sfs_cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // A status read without an armed count read leaves the FIFO alone
  pop_once_a: assert property (
    (rd_status && !st.armed) |-> !pop)
    else $error("status read popped without count read");

  // Empty FIFO never pops
  no_underflow_a: assert property (
    !not_empty |-> !pop)
    else $error("pop from empty status FIFO");

  // Count-high read returns availability bit as it stood
  avail_bit_a: assert property (
    (rd_cnt_high && fifo_en) |=>
      reg_rvalid_o && reg_rdata_o[`SFS_CNTH_AVAIL_BIT] ==
        $past(active & not_empty))
    else $error("count-high availability bit wrong");

  // Overflow stays set while the FIFO stays enabled
  ovf_sticky_a: assert property (
    (ce_i && st.overflow && fifo_en) |=> st.overflow)
    else $error("overflow cleared while enabled");

  // Overflow follows a push into a full FIFO
  ovf_set_a: assert property (
    (ce_i && fifo_en && push_req && !in_ready) |=> st.overflow)
    else $error("overflow not flagged");

  // Flag clears the byte counter after its value was pushed
  cnt_reset_a: assert property (
    (ce_i && active && rx_flag_i && !rx_data_wr_i) |=>
      st.byte_cnt == '0)
    else $error("byte counter not cleared on flag");

  // Each receive data write adds one
  cnt_inc_a: assert property (
    (ce_i && active && rx_data_wr_i && !rx_flag_i) |=>
      st.byte_cnt == `SFS_CNT_W'($past(st.byte_cnt) + 1'b1))
    else $error("byte counter missed a write");

  // Counter idles at zero outside SDLC with FIFO on
  cnt_idle_a: assert property (
    (ce_i && !active) |=> st.byte_cnt == '0)
    else $error("byte counter ran while disabled");

  // Option writes are redirected away from the sync flag register
  redirect_a: assert property (
    (ce_i && reg_wr_i && reg_idx_i == `SFS_IX_SYNC_FLAG && opt_en) |=>
      st.cfg.option == $past(reg_wdata_i) && $stable(st.cfg.sync_flag))
    else $error("sync flag write not redirected");

  // Extended read returns the option register at its readback pointer
  opt_readback_a: assert property (
    (ce_i && reg_rd_i && reg_idx_i == `SFS_IX_OPT_RB && ext_rd) |=>
      reg_rdata_o == $past(st.cfg.option))
    else $error("option readback wrong");

  // Request-to-send held after software clears it under auto turnoff
  rts_hold_a: assert property (
    (ce_i && st.rts_hold && !closing_flag_done_i && opt_en &&
     sdlc_mode_i && st.cfg.option[`SFS_OPT_AUTO_RTS] && !reg_wr_i) |=>
      rts_o)
    else $error("request-to-send dropped early");

  // Status read of an armed non-empty FIFO shows the head's residue
  fifo_status_a: assert property (
    (ce_i && rd_status && use_fifo) |=>
      reg_rdata_o[3:1] == $past(head.residue))
    else $error("status not taken from FIFO head");
endmodule : sfs_frame_status

// ### sfs_host_model.sv
// Host model: register reads and writes on the parallel port
`timescale 1ns/1ps
module sfs_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Register port
  output logic [3:0]      reg_idx_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial {reg_idx_o, reg_rd_o, reg_wr_o, reg_wdata_o} = '0;

  // One strobe cycle; a missing valid pulse turns the read into unknowns
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    {reg_idx_o, reg_wdata_o} <= {a, d};
    {reg_rd_o, reg_wr_o} <= {~w, w};
    @(posedge clk_sys_i);
    {reg_rd_o, reg_wr_o} <= 2'h0;
    reg_wdata_o <= ~d; // Released data never shows the last value
    #1 q = reg_rvalid_i ? reg_rdata_i : 8'hxx;
  endtask : acc

  // Count first so the pop cannot lose the count
  task automatic frame_rd(output logic [7:0] h, l, s);
    acc(1'h0, 4'h7, 8'h00, h);
    acc(1'h0, 4'h6, 8'h00, l);
    acc(1'h0, 4'h1, 8'h00, s);
  endtask : frame_rd
endmodule : sfs_host_model

// ### sfs_frame_status_bench.sv
// Self-checking bench for the frame status block
`timescale 1ns/1ps
module sfs_frame_status_bench
  import sfs_pkg::*;
;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, sdlc_mode_i = 1'h1;
  logic rx_data_wr_i = 1'h0, rx_flag_i = 1'h0, rx_eof_i = 1'h0;
  logic closing_flag_done_i = 1'h0, reg_rd_i, reg_wr_i, reg_rvalid_o;
  logic rts_o, fifo_active_o, status_lost_o;
  logic [3:0] reg_idx_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, q, h, l, s, fq [3];
  logic [2:0] nq [3];
  sfs_core_stat_t core_stat_i = '0;
  sfs_cfg_regs_t cfg_o;
  sfs_ctrl_t ctrl_o;
  logic [31:0] lfsr = 32'h372b;
  int fails = 0, check_count = 0, cycles = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  sfs_frame_status DUT (.clk_sys_i, .rst_i, .ce_i, .reg_idx_i, .reg_rd_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .sdlc_mode_i,
    .rx_data_wr_i, .rx_flag_i, .rx_eof_i, .closing_flag_done_i,
    .core_stat_i, .cfg_o, .ctrl_o, .rts_o, .fifo_active_o, .status_lost_o);
  sfs_host_model host (.clk_sys_i, .reg_idx_o(reg_idx_i),
    .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  // Kept bits come from the stored frame, the rest stay live
  function automatic logic [7:0] xst(input logic [7:0] f, lv);
    return {lv[7], f[6:5], lv[4], f[3:1], lv[0]};
  endfunction : xst

  task automatic chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // n received bytes, then a closing flag with end of frame
  task automatic frame(input int n, input logic [7:0] f);
    core_stat_i.rx_cond <= f;
    repeat (n) @(posedge clk_sys_i) rx_data_wr_i <= 1'h1;
    @(posedge clk_sys_i) {rx_data_wr_i, rx_eof_i, rx_flag_i} <= 3'h3;
    @(posedge clk_sys_i) {rx_eof_i, rx_flag_i} <= 2'h0;
  endtask : frame

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(posedge clk_sys_i);
    #1 chk(cfg_o.option, 8'h00);
    host.acc(1'h1, 4'hf, 8'h04, q);
    chk({7'h00, fifo_active_o}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      {nq[i], fq[i]} = {lfsr[2:0], lfsr[15:8]};
      frame(nq[i], fq[i]);
    end
    core_stat_i.rx_cond <= 8'h5a;
    for (int i = 0; i < 3; i++) begin
      host.frame_rd(h, l, s);
      chk(h, 8'h40);
      chk(l, {5'h00, nq[i]});
      chk(s, xst(fq[i], 8'h5a));
    end
    host.acc(1'h0, 4'h1, 8'h00, s);
    chk(s, 8'h5a);
    host.acc(1'h0, 4'h7, 8'h00, h);
    chk(h & 8'hc0, 8'h00);
    $display("frame test done");
    for (int i = 1; i <= 11; i++) begin
      frame(0, 8'h00);
      #1 chk({7'h00, status_lost_o}, {7'h00, i == 11});
    end
    host.acc(1'h0, 4'h7, 8'h00, h);
    chk(h & 8'hc0, 8'hc0);
    host.acc(1'h1, 4'hf, 8'h00, q);
    host.acc(1'h1, 4'hf, 8'h04, q);
    host.acc(1'h0, 4'h7, 8'h00, h);
    chk(h & 8'hc0, 8'h00);
    $display("overflow test done");
    host.acc(1'h1, 4'hf, 8'h01, q);
    host.acc(1'h1, 4'h7, 8'h74, q);
    chk(cfg_o.option, 8'h74);
    chk({3'h0, ctrl_o}, 8'h03);
    host.acc(1'h1, 4'h3, lfsr[7:0], q);
    host.acc(1'h0, 4'h9, 8'h00, s);
    chk(s, lfsr[7:0]);
    host.acc(1'h1, 4'ha, 8'h08, q);
    host.acc(1'h1, 4'h5, 8'h02, q);
    host.acc(1'h1, 4'h5, 8'h00, q);
    repeat (2) @(posedge clk_sys_i);
    #1 chk({7'h00, rts_o}, 8'h01);
    @(posedge clk_sys_i) closing_flag_done_i <= 1'h1;
    @(posedge clk_sys_i) closing_flag_done_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk({7'h00, rts_o}, 8'h00);
    $display("option test done");
    complete_run();
  end
endmodule : sfs_frame_status_bench
